//--- hw/sac_consts.svh
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register byte offsets
`define SAC_OFF_CTRL_ONE     12'h000
`define SAC_OFF_CTRL_TWO     12'h004
`define SAC_OFF_RESULT_HIGH  12'h008
`define SAC_OFF_RESULT_LOW   12'h00C
`define SAC_OFF_COMPARE      12'h010
`define SAC_OFF_CONFIG       12'h014

// control one fields
`define SAC_C1_FLAG_BIT      7
`define SAC_C1_IEN_BIT       6
`define SAC_C1_CONT_BIT      5
`define SAC_C1_CH_MSB        4
`define SAC_C1_RESET         8'h1F

// control two fields
`define SAC_C2_ACTIVE_BIT    7
`define SAC_C2_HWT_BIT       6
`define SAC_C2_CMPE_BIT      5
`define SAC_C2_CMPGE_BIT     4
`define SAC_C2_RESET         8'h00

// config fields
`define SAC_CFG_DIV_MSB      6
`define SAC_CFG_DIV_LSB      5
`define SAC_CFG_LONG_BIT     4
`define SAC_CFG_TEN_BIT      3
`define SAC_CFG_SRC_MSB      1
`define SAC_CFG_SRC_LSB      0
`define SAC_CFG_RESET        8'h00

// channel codes
`define SAC_CH_PIN_LAST      5'h0B
`define SAC_CH_GND_FIRST     5'h0C
`define SAC_CH_GND_LAST      5'h14
`define SAC_CH_TEMP          5'h1A
`define SAC_CH_BANDGAP       5'h1B
`define SAC_CH_REF_HIGH      5'h1D
`define SAC_CH_REF_LOW       5'h1E
`define SAC_CH_OFF           5'h1F

// clock sources
`define SAC_SRC_BUS          2'h0
`define SAC_SRC_BUS_HALF     2'h1
`define SAC_SRC_ALT          2'h2
`define SAC_SRC_LOCAL        2'h3

// power modes
`define SAC_PM_RUN           2'h0
`define SAC_PM_WAIT          2'h1
`define SAC_PM_STOP3         2'h2
`define SAC_PM_STOP2         2'h3

// sample phase length in conversion clocks
`define SAC_SAMPLE_SHORT     5'h04
`define SAC_SAMPLE_LONG      5'h14

`define SAC_SAR_TOP          10'h200
`define SAC_RESULT_BITS      10

`endif

//--- hw/sac_pkg.sv
package sac_pkg;

   typedef enum logic [1:0] {
      SAC_IDLE    = 2'b00,
      SAC_SAMPLE  = 2'b01,
      SAC_CONVERT = 2'b10,
      SAC_FINISH  = 2'b11
   } sac_state_t;

   // analog input routing
   typedef struct packed {
      logic [11:0] pin_sel;
      logic        gnd_sel;
      logic        temp_sel;
      logic        bandgap_sel;
      logic        ref_high_sel;
      logic        ref_low_sel;
   } sac_mux_t;

endpackage

//--- hw/sac_ctrl.sv
//  Contract
// [RULE1] decode channel codes to pins, ground, temperature sensor, bandgap or disable
// [RULE2] reserved channel codes route nothing; result then has no defined value
// [RULE3] software enables the bandgap buffer before converting the bandgap channel
// [RULE4] conversion input clock comes from one of four selectable sources
// [RULE5] selected source divided by the divide field forms the conversion clock
// [RULE6] alternate clock keeps running in wait mode
// [RULE7] software avoids the alternate clock when entering either stop mode
// [RULE8] with hardware triggering on, each counter overflow starts one conversion
// [RULE9] trigger is produced regardless of the counter interrupt enable
// [RULE10] hardware trigger starts conversions in run, wait and stop3
// [RULE11] software sets long sample and slow clock before the temperature channel
// [RULE12] linear successive approximation producing ten result bits
// [RULE13] result delivered right justified in ten or eight bit form
// [RULE14] single conversions return to idle; continuous runs back to back
// [RULE15] compare result less-than or greater-equal; flag only when true
// [RULE16] completion flag sets at end; interrupt raised when enabled
// [RULE17] conversions continue in wait and stop3 using the local clock
// [RULE18] writing control one aborts and restarts unless channel is all ones
// [RULE19] completion flag clears on control one write or low result read
// [RULE20] trigger synchronised, one start per overflow, ignored while active
// [RULE21] reset leaves block idle, channel all ones, converter off, flag clear
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_ctrl (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // system
   input  wire logic [1:0]        power_mode,
   input  wire logic              local_async_conv_clock,
   input  wire logic              alternate_clock,
   input  wire logic              hw_conversion_trigger,
   // analog front end
   input  wire logic              comparator_out,
   output sac_pkg::sac_mux_t      analog_mux,
   output logic [9:0]             dac_code,
   output logic                   sample_en,
   output logic                   conv_power,
   // interrupt
   output logic                   conv_irq
);
   import sac_pkg::*;

   // channel decode; reserved codes leave every select low
   function automatic sac_mux_t decode_ch(input logic [4:0] ch);
      sac_mux_t m;
      m = '0;
      if (ch <= `SAC_CH_PIN_LAST) begin
         m.pin_sel = 12'(12'h001 << ch); // [RULE1]
      end else if (ch >= `SAC_CH_GND_FIRST && ch <= `SAC_CH_GND_LAST) begin
         m.gnd_sel = 1'b1;
      end else if (ch == `SAC_CH_TEMP) begin
         m.temp_sel = 1'b1;
      end else if (ch == `SAC_CH_BANDGAP) begin
         m.bandgap_sel = 1'b1;
      end else if (ch == `SAC_CH_REF_HIGH) begin
         m.ref_high_sel = 1'b1;
      end else if (ch == `SAC_CH_REF_LOW) begin
         m.ref_low_sel = 1'b1;
      end
      return m; // [RULE2]
   endfunction

   // registers
   logic [7:0]  ctrl_one_r;
   logic [7:0]  ctrl_two_r;
   logic [7:0]  config_r;
   logic [9:0]  compare_r;
   logic [9:0]  result_r;
   logic        flag_r;
   sac_state_t  state_r;
   sac_state_t  state_nxt;
   logic [9:0]  sar_r;
   logic [3:0]  bit_idx_r;
   logic [4:0]  sample_cnt_r;
   logic [2:0]  div_cnt_r;
   logic        bus_half_r;
   logic [2:0]  sync1_r;
   logic [2:0]  sync2_r;
   logic        trig_prev_r;
   logic        local_prev_r;
   logic        alt_prev_r;
   logic        comp_sync1_r;
   logic        comp_sync2_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   sac_mux_t    mux_r;
   logic [9:0]  dac_r;
   logic        sample_en_r;
   logic        power_r;
   logic        irq_r;

   // apb decode
   wire         acc_done   = psel & penable & pready_r;
   wire         wr_done    = acc_done & pwrite;
   wire         rd_done    = acc_done & ~pwrite;
   wire         hit_c1     = (paddr == `SAC_OFF_CTRL_ONE);
   wire         hit_c2     = (paddr == `SAC_OFF_CTRL_TWO);
   wire         hit_rh     = (paddr == `SAC_OFF_RESULT_HIGH);
   wire         hit_rl     = (paddr == `SAC_OFF_RESULT_LOW);
   wire         hit_cmp    = (paddr == `SAC_OFF_COMPARE);
   wire         hit_cfg    = (paddr == `SAC_OFF_CONFIG);
   // unmapped addresses answer with an error and read as zero
   wire         mapped     = hit_c1 | hit_c2 | hit_rh | hit_rl | hit_cmp | hit_cfg;
   wire         wr_c1      = wr_done & hit_c1;
   wire [4:0]   wr_ch      = pwdata[`SAC_C1_CH_MSB:0];
   wire [4:0]   channel    = ctrl_one_r[`SAC_C1_CH_MSB:0];
   wire         hw_mode    = ctrl_two_r[`SAC_C2_HWT_BIT];
   wire         cmp_en     = ctrl_two_r[`SAC_C2_CMPE_BIT];
   wire         cmp_ge     = ctrl_two_r[`SAC_C2_CMPGE_BIT];
   wire         continuous = ctrl_one_r[`SAC_C1_CONT_BIT];
   wire         active     = (state_r != SAC_IDLE);

   // formatted result: eight bit form keeps the top eight bits
   wire         ten_bit    = config_r[`SAC_CFG_TEN_BIT];
   wire [9:0]   fmt_result = ten_bit ? sar_r : {2'b00, sar_r[9:2]}; // [RULE13]

   wire [31:0]  rd_data =
      hit_c1  ? {24'h000000, flag_r, ctrl_one_r[6:0]} :
      hit_c2  ? {24'h000000, active, ctrl_two_r[6:0]} :
      hit_rh  ? {30'h0000000, result_r[9:8]} :
      hit_rl  ? {24'h000000, result_r[7:0]} :
      hit_cmp ? {22'h00000, compare_r} :
      hit_cfg ? {24'h000000, config_r} : 32'h00000000;

   // input synchronisers: trigger, local clock, alternate clock
   wire         trig_s   = sync2_r[0];
   wire         local_s  = sync2_r[1];
   wire         alt_s    = sync2_r[2];
   // one start event per rising edge of the synchronised overflow
   wire         trig_evt = trig_s & ~trig_prev_r; // [RULE20]
   wire         local_tk = local_s & ~local_prev_r;
   wire         alt_tk   = alt_s & ~alt_prev_r;

   // clock source choice; bus clock is gone in stop3 and stop2, so fall back to the local clock
   wire         in_stop  = (power_mode == `SAC_PM_STOP3) | (power_mode == `SAC_PM_STOP2);
   wire [1:0]   src      = config_r[`SAC_CFG_SRC_MSB:`SAC_CFG_SRC_LSB];
   wire         bus_src  = (src == `SAC_SRC_BUS) | (src == `SAC_SRC_BUS_HALF);
   // alternate source stalls in stop; software must not pick it there
   wire         alt_ok   = alt_tk & ~in_stop; // [RULE6]
   wire         src_tick =
      (bus_src & in_stop)        ? local_tk : // [RULE17]
      (src == `SAC_SRC_BUS)      ? 1'b1 :
      (src == `SAC_SRC_BUS_HALF) ? bus_half_r :
      (src == `SAC_SRC_ALT)      ? alt_ok : local_tk; // [RULE4]

   // divider by 1, 2, 4 or 8
   wire [1:0]   div_sel  = config_r[`SAC_CFG_DIV_MSB:`SAC_CFG_DIV_LSB];
   wire [2:0]   div_top  = 3'(3'h1 << div_sel) - 3'h1;
   wire         conv_tick = src_tick & (div_cnt_r == div_top); // [RULE5]

   // start conditions
   wire         ch_on    = (channel != `SAC_CH_OFF);
   // a write in trigger mode only arms; the next overflow starts the conversion
   wire         sw_start = wr_c1 & (wr_ch != `SAC_CH_OFF) & ~hw_mode; // [RULE18]
   wire         hw_start = hw_mode & ch_on & trig_evt & ~active; // [RULE8]

   // compare and completion
   // eight bit form compares the formatted result, so software writes an eight bit value
   wire         cmp_true = cmp_ge ? (fmt_result >= compare_r) : (fmt_result < compare_r);
   wire         finish   = (state_r == SAC_FINISH);
   wire         accept   = finish & (~cmp_en | cmp_true); // [RULE15]
   wire         flag_clr = wr_c1 | (rd_done & hit_rl);
   // set wins over a clear in the same cycle so no completion is lost
   wire         flag_nxt = accept | (flag_r & ~flag_clr); // [RULE16]
   wire [4:0]   samp_len = config_r[`SAC_CFG_LONG_BIT] ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
   wire         keep_bit = comp_sync2_r;

   // conversion sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SAC_IDLE: begin
            if (hw_start) begin
               state_nxt = SAC_SAMPLE;
            end
         end
         SAC_SAMPLE: begin
            if (conv_tick && sample_cnt_r == samp_len - 5'h01) begin
               state_nxt = SAC_CONVERT;
            end
         end
         SAC_CONVERT: begin
            if (conv_tick && bit_idx_r == 4'h0) begin
               state_nxt = SAC_FINISH; // [RULE12]
            end
         end
         SAC_FINISH: begin
            if (continuous && ch_on) begin
               state_nxt = SAC_SAMPLE; // [RULE14]
            end else begin
               state_nxt = SAC_IDLE;
            end
         end
         default: state_nxt = SAC_IDLE;
      endcase
      if (wr_c1) begin
         state_nxt = sw_start ? SAC_SAMPLE : SAC_IDLE; // [RULE18]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r      <= 3'h0;
         sync2_r      <= 3'h0;
         comp_sync1_r <= 1'b0;
         comp_sync2_r <= 1'b0;
         trig_prev_r  <= 1'b0;
         local_prev_r <= 1'b0;
         alt_prev_r   <= 1'b0;
      end else begin
         sync1_r      <= {alternate_clock, local_async_conv_clock, hw_conversion_trigger};
         sync2_r      <= sync1_r;
         comp_sync1_r <= comparator_out;
         comp_sync2_r <= comp_sync1_r;
         trig_prev_r  <= trig_s; // [RULE9]
         local_prev_r <= local_s;
         alt_prev_r   <= alt_s;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_half_r <= 1'b0;
         div_cnt_r  <= 3'h0;
      end else begin
         bus_half_r <= ~bus_half_r;
         // a restart by write begins the divider afresh, so the first tick is a full period
         if (!active || wr_c1) begin
            div_cnt_r <= 3'h0;
         end else if (src_tick) begin
            div_cnt_r <= (div_cnt_r == div_top) ? 3'h0 : div_cnt_r + 3'h1;
         end
      end
   end

   // apb: one wait state so read data leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & ~mapped;
         if (psel && penable && !pready_r && !pwrite) begin
            prdata_r <= rd_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_one_r <= `SAC_C1_RESET; // [RULE21]
         ctrl_two_r <= `SAC_C2_RESET;
         config_r   <= `SAC_CFG_RESET;
         compare_r  <= 10'h000;
      end else if (wr_done) begin
         if (hit_c1) begin
            ctrl_one_r <= {1'b0, pwdata[6:0]};
         end
         if (hit_c2) begin
            ctrl_two_r <= {1'b0, pwdata[6:4], 4'h0};
         end
         if (hit_cfg) begin
            config_r <= {1'b0, pwdata[6:0]};
         end
         if (hit_cmp) begin
            compare_r <= pwdata[9:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r      <= SAC_IDLE;
         flag_r       <= 1'b0;
         result_r     <= 10'h000;
         sar_r        <= 10'h000;
         bit_idx_r    <= 4'h0;
         sample_cnt_r <= 5'h00;
      end else begin
         state_r <= state_nxt; // [RULE10]
         flag_r  <= flag_nxt; // [RULE19]
         if (accept) begin
            result_r <= fmt_result;
         end
         // abort and restart inside the sample phase must give a full sample phase again
         if (state_nxt == SAC_SAMPLE && (state_r != SAC_SAMPLE || wr_c1)) begin
            sample_cnt_r <= 5'h00;
         end else if (state_r == SAC_SAMPLE && conv_tick) begin
            sample_cnt_r <= sample_cnt_r + 5'h01;
         end
         if (state_r != SAC_CONVERT && state_nxt == SAC_CONVERT) begin
            sar_r     <= `SAC_SAR_TOP;
            bit_idx_r <= 4'(`SAC_RESULT_BITS - 1);
         end else if (state_r == SAC_CONVERT && conv_tick && !wr_c1) begin
            // comparator lags three bus cycles (dac register and two sync flops); divide so a conversion clock spans more
            sar_r[bit_idx_r] <= keep_bit;
            if (bit_idx_r != 4'h0) begin
               sar_r[bit_idx_r - 4'h1] <= 1'b1;
               bit_idx_r <= bit_idx_r - 4'h1;
            end
         end
      end
   end

   // outputs to the analog side and the interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_r       <= '0;
         dac_r       <= 10'h000;
         sample_en_r <= 1'b0;
         power_r     <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         mux_r       <= decode_ch(channel); // [RULE1]
         dac_r       <= sar_r;
         sample_en_r <= (state_r == SAC_SAMPLE);
         power_r     <= active & ch_on; // [RULE1]
         irq_r       <= flag_r & ctrl_one_r[`SAC_C1_IEN_BIT]; // [RULE16]
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign analog_mux = mux_r;
   assign dac_code   = dac_r;
   assign sample_en  = sample_en_r;
   assign conv_power = power_r;
   assign conv_irq   = irq_r;

endmodule

//--- tb/sac_ctrl_checker.sv
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_ctrl_checker (
   // apb
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   // converter
   input wire sac_pkg::sac_mux_t analog_mux,
   input wire logic [9:0]        dac_code,
   input wire logic              sample_en,
   input wire logic              conv_power,
   input wire logic              conv_irq
);
   import sac_pkg::*;
   logic [4:0] chan_r;
   logic [3:0] idle_r;
   wire logic  xfer   = psel && penable && pready;
   wire logic  wr_one = xfer && pwrite && paddr == `SAC_OFF_CTRL_ONE;
   wire logic  rd_low = xfer && !pwrite && paddr == `SAC_OFF_RESULT_LOW;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) chan_r <= `SAC_CH_OFF;
      else if (wr_one) chan_r <= pwdata[4:0];
   end
   // cycles since the converter last showed activity, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) idle_r <= 4'h0;
      else if (conv_power || sample_en) idle_r <= 4'h0;
      else if (idle_r != 4'hF) idle_r <= idle_r + 4'h1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_reset_idle: assert property ($rose(presetn) |-> analog_mux == '0 && !conv_power)
      else $error("converter active after reset");
   a_mux_onehot: assert property ($onehot0(analog_mux))
      else $error("more than one input routed");
   a_pin_decode: assert property (wr_one ##1 chan_r < 5'h0C
      |-> ##[0:2] analog_mux.pin_sel == (12'h001 << chan_r)) else $error("pin decode");
   a_gnd_decode: assert property (wr_one ##1 chan_r inside {[5'h0C:5'h14]}
      |-> ##[0:2] analog_mux.gnd_sel) else $error("ground decode");
   a_temp_decode: assert property (wr_one ##1 chan_r == 5'h1A
      |-> ##[0:2] analog_mux.temp_sel) else $error("temperature decode");
   a_rsvd_quiet: assert property (wr_one ##1 chan_r inside {[5'h15:5'h19], 5'h1C}
      |-> ##[1:2] analog_mux == '0) else $error("reserved code routed");
   a_off_stop: assert property (wr_one ##1 chan_r == `SAC_CH_OFF
      |-> ##[0:2] !conv_power) else $error("disable did not stop");
   a_clr_on_write: assert property (wr_one |=> ##1 !conv_irq)
      else $error("irq kept after control write");
   a_clr_on_read: assert property (rd_low |=> ##1 !conv_irq)
      else $error("irq kept after low read");
   a_irq_after_conv: assert property ($rose(conv_irq) |-> idle_r < 4'h4)
      else $error("irq without conversion");
   a_sar_start: assert property ($fell(sample_en) ##1 conv_power
      |-> ##[0:20] dac_code == `SAC_SAR_TOP) else $error("trial did not start at top");
endmodule

//--- tb/sac_afe_model.sv
`timescale 1ns/1ps
module sac_afe_model (
   // bench side
   input  wire logic              pclk,
   input  wire logic              fire,
   // device side
   input  wire sac_pkg::sac_mux_t analog_mux,
   input  wire logic [9:0]        dac_code,
   output logic                   comparator_out,
   output logic                   local_clk,
   output logic                   alt_clk,
   output logic                   ovf
);
   import sac_pkg::*;
   logic [9:0] lvl;
   logic [2:0] hold_r = 3'h0;
   initial local_clk = 1'b0;
   initial alt_clk = 1'b0;
   always #40 local_clk = ~local_clk;
   always #45 alt_clk = ~alt_clk;
   always_comb begin
      lvl = 10'h000;
      for (int k = 0; k < 12; k++)
         if (analog_mux.pin_sel[k]) lvl = 10'(k * 64 + 21);
      if (analog_mux.temp_sel) lvl = 10'h155;
      if (analog_mux.bandgap_sel) lvl = 10'h2AA;
      if (analog_mux.ref_high_sel) lvl = 10'h3FF;
   end
   // an unrouted input floats, so it must not settle to a value
   assign comparator_out = (analog_mux == '0) ? pclk : (lvl >= dac_code);
   // overflow is stretched so a 2-flop synchroniser always sees it; no interrupt gate
   always @(posedge pclk) begin
      if (fire) hold_r <= 3'h4;
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
   end
   assign ovf = (hold_r != 3'h0);
endmodule

//--- tb/sac_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "sac_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module sac_ctrl_tb_top;
   import sac_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0]  power_mode = `SAC_PM_RUN;
   logic [9:0]  dac_code;
   logic        pready, pslverr, cmp, lclk, aclk, ovf, sample_en, conv_power, conv_irq;
   sac_mux_t    analog_mux;
   int          num_errors = 0, n_checks = 0, cyc = 0;
   always #5 pclk = ~pclk;
   sac_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_mode(power_mode), .local_async_conv_clock(lclk),
      .alternate_clock(aclk), .hw_conversion_trigger(ovf), .comparator_out(cmp),
      .analog_mux(analog_mux), .dac_code(dac_code), .sample_en(sample_en),
      .conv_power(conv_power), .conv_irq(conv_irq));
   sac_afe_model i_afe (.pclk(pclk), .fire(fire), .analog_mux(analog_mux),
      .dac_code(dac_code), .comparator_out(cmp), .local_clk(lclk), .alt_clk(aclk), .ovf(ovf));
   function automatic logic [9:0] pin(input int k);
      return 10'(k * 64 + 21);
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_flag();
      rd = 0;
      for (int i = 0; i < 400 && rd[7] !== 1'b1; i++) apb(0, `SAC_OFF_CTRL_ONE, 0);
      `CHK(rd[7], 1'b1)
   endtask
   task automatic pulse();
      @(posedge pclk);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
   endtask
   task automatic conv(input logic [7:0] c1, input logic [9:0] e, input logic hw = 0);
      logic [1:0] hi;
      apb(1, `SAC_OFF_CTRL_ONE, {24'h0, c1});
      if (hw) pulse();
      wait_flag();
      apb(0, `SAC_OFF_RESULT_HIGH, 0);
      hi = rd[1:0];
      apb(0, `SAC_OFF_RESULT_LOW, 0);
      `CHK({hi, rd[7:0]}, e)
      apb(0, `SAC_OFF_CTRL_ONE, 0);
      `CHK(rd[7], 1'b0)
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `SAC_OFF_CTRL_ONE, 0);
      `CHK(rd[7:0], `SAC_C1_RESET)
      apb(0, 12'h020, 0);
      `CHK({err, rd}, 33'h100000000)
      apb(1, `SAC_OFF_CONFIG, 32'h68);
      for (int k = 0; k < 12; k++) conv(8'(k), pin(k));
      `CHK(conv_power, 1'b0)
      conv(8'h0C, 10'h000);
      conv(8'h14, 10'h000);
      apb(1, `SAC_OFF_CONFIG, 32'h78);
      conv(8'h1B, 10'h2AA);
      conv(8'h1A, 10'h155);
      conv(8'h1D, 10'h3FF);
      conv(8'h1E, 10'h000);
      for (int s = 0; s < 4; s++) begin
         power_mode <= (s == 2) ? `SAC_PM_WAIT : `SAC_PM_RUN;
         apb(1, `SAC_OFF_CONFIG, 32'h68 | s);
         conv(8'h07, pin(7));
      end
      power_mode <= `SAC_PM_STOP3;
      apb(1, `SAC_OFF_CONFIG, 32'h68);
      conv(8'h09, pin(9));
      power_mode <= `SAC_PM_RUN;
      apb(1, `SAC_OFF_CONFIG, 32'h48);
      conv(8'h08, pin(8));
      apb(1, `SAC_OFF_CONFIG, 32'h29);
      conv(8'h02, pin(2));
      apb(1, `SAC_OFF_CONFIG, 32'h0B);
      conv(8'h0B, pin(11));
      apb(1, `SAC_OFF_CONFIG, 32'h60);
      conv(8'h05, pin(5) >> 2);
      apb(1, `SAC_OFF_CONFIG, 32'h68);
      apb(1, `SAC_OFF_CTRL_ONE, 32'h43);
      for (int i = 0; i < 400 && conv_irq !== 1'b1; i++) @(posedge pclk);
      `CHK(conv_irq, 1'b1)
      apb(1, `SAC_OFF_CTRL_ONE, 32'h5F);
      apb(0, `SAC_OFF_CTRL_ONE, 0);
      `CHK({conv_power, rd[7:0]}, 9'h05F)
      apb(1, `SAC_OFF_CTRL_ONE, 32'h16);
      apb(1, `SAC_OFF_CTRL_ONE, 32'h02);
      repeat (30) @(posedge pclk);
      conv(8'h03, pin(3));
      apb(1, `SAC_OFF_COMPARE, 32'h200);
      apb(1, `SAC_OFF_CTRL_TWO, 32'h30);
      apb(1, `SAC_OFF_CTRL_ONE, 32'h01);
      repeat (300) @(posedge pclk);
      apb(0, `SAC_OFF_CTRL_ONE, 0);
      `CHK(rd[7], 1'b0)
      conv(8'h0A, pin(10));
      apb(1, `SAC_OFF_CTRL_TWO, 32'h20);
      conv(8'h01, pin(1));
      apb(1, `SAC_OFF_CTRL_TWO, 32'h00);
      conv(8'h24, pin(4));
      wait_flag();
      `CHK(rd[7], 1'b1)
      apb(1, `SAC_OFF_CTRL_ONE, 32'h1F);
      apb(1, `SAC_OFF_CTRL_TWO, 32'h40);
      // trigger in every mode where the counter may still run
      for (int m = 0; m < 3; m++) begin
         power_mode <= 2'(m);
         conv(8'h06, pin(6), 1'b1);
      end
      power_mode <= `SAC_PM_RUN;
      pulse();
      repeat (20) @(posedge pclk);
      pulse();
      wait_flag();
      apb(0, `SAC_OFF_RESULT_LOW, 0);
      repeat (300) @(posedge pclk);
      apb(0, `SAC_OFF_CTRL_ONE, 0);
      `CHK(rd[7], 1'b0)
      report_and_stop();
   end
endmodule
bind sac_ctrl sac_ctrl_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .analog_mux(analog_mux), .dac_code(dac_code), .sample_en(sample_en),
   .conv_power(conv_power), .conv_irq(conv_irq));
